// [rtl/wcd_core.v]
`timescale 1ns/1ps
`include "wcd_regs.vh"

// Operation
// RL1: watchdog clear op loads the watchdog counter with zero.
// RL2: watchdog clear op also clears the watchdog prescaler, same instruction.
// RL3: watchdog clear op sets timeout_flag_n and powerdown_flag_n; other flags untouched.
// RL4: opcode 00 0000 0110 0100 is the watchdog clear op, one word, one cycle.
// RL5: decrement takes a 7-bit register index 0..127 and a one-bit destination.
// RL6: decrement is upper bits 00 0011, then destination bit, then seven index bits.
// RL7: destination zero puts register minus one into the accumulator, register unchanged.
// RL8: destination one writes the decremented value back into the register.
// RL9: decrement updates the zero flag only, other flags unchanged.
// RL10: decrement wraps 0x00 to 0xff, zero flag on zero result, one cycle; here the result lands two edges after the issuing edge.
module wcd_core #(
    parameter PRE_W = 8,
    parameter IDX_W = 7
) (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        ce,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    output wire [7:0]  watchdog_counter,
    output wire        timeout_flag_n,
    output wire        powerdown_flag_n,
    output wire        zero_flag,
    output reg         wdog_timeout
);

    // ---------------------------------------------------------------
    // state and registers
    // ---------------------------------------------------------------
    localparam ST_IDLE = 2'b00;
    localparam ST_READ = 2'b01;
    localparam ST_EXEC = 2'b10;

    reg  [1:0]       state_r;
    reg  [1:0]       state_nxt;
    reg              wdog_en_r;
    reg  [7:0]       acc_r;
    reg              zero_r;
    reg              pd_n_r;
    reg              to_n_r;
    reg              bad_op_r;
    reg  [7:0]       wdog_r;
    reg  [PRE_W-1:0] pre_r;
    reg  [IDX_W-1:0] faddr_r;
    reg  [IDX_W-1:0] dec_idx_r;
    reg              dec_dest_r;
    reg              rd_wait_r;
    reg  [1:0]       settle_r;

    wire [7:0]       mem_rdata;
    wire [7:0]       dec_res;
    wire             dec_zero;
    wire             mem_we;
    wire [IDX_W-1:0] mem_waddr;
    wire [7:0]       mem_wdata;
    wire [IDX_W-1:0] mem_raddr;
    wire             pre_wrap;
    wire             wdog_timeout_nxt;

    // ---------------------------------------------------------------
    // bus decode
    // ---------------------------------------------------------------
    wire sel_ctrl   = (paddr == `WCD_OFS_CTRL);
    wire sel_instr  = (paddr == `WCD_OFS_INSTR);
    wire sel_acc    = (paddr == `WCD_OFS_ACC);
    wire sel_status = (paddr == `WCD_OFS_STATUS);
    wire sel_wdog   = (paddr == `WCD_OFS_WDOG);
    wire sel_faddr  = (paddr == `WCD_OFS_FADDR);
    wire sel_fdata  = (paddr == `WCD_OFS_FDATA);
    wire sel_any    = sel_ctrl | sel_instr | sel_acc | sel_status |
                      sel_wdog | sel_faddr | sel_fdata;

    // a read of the file array waits one cycle for the registered memory
    wire fd_read    = psel & penable & ~pwrite & sel_fdata;

    // every access stalls while a decrement is in flight and for two
    // settle cycles after it, so the registered read data and the array
    // read port both show the result before pready rises
    assign pready   = ce & (state_r == ST_IDLE) & (settle_r == 2'h0) &
                      (~fd_read | rd_wait_r);
    assign pslverr  = ~sel_any;

    wire acc_phase  = psel & penable & pready;
    wire wr_en      = acc_phase & pwrite & sel_any;

    // ---------------------------------------------------------------
    // instruction decode
    // ---------------------------------------------------------------
    wire [`WCD_OP_WIDTH-1:0] opcode = pwdata[`WCD_OP_WIDTH-1:0];
    wire op_wdog_clr = (opcode == `WCD_OP_WDOG_CLR);                   // RL4
    wire op_dec      = (opcode[`WCD_OP_HI_MSB:`WCD_OP_HI_LSB]
                        == `WCD_OP_DEC_HI);                            // RL6
    wire issue       = wr_en & sel_instr;
    wire do_clr      = issue & op_wdog_clr;
    wire do_dec      = issue & op_dec;
    wire do_bad      = issue & ~op_wdog_clr & ~op_dec;

    // ---------------------------------------------------------------
    // decrement datapath
    // ---------------------------------------------------------------
    // 8-bit subtraction wraps 0x00 to 0xff on its own
    assign dec_res  = mem_rdata - `WCD_DEC_STEP;                       // RL10
    assign dec_zero = (dec_res == `WCD_ZERO8);                         // RL10
    wire   exec     = ce & (state_r == ST_EXEC);

    // array write: the decrement owns the port in its execute cycle,
    // software writes cannot collide since the bus is stalled then
    assign mem_we    = (exec & dec_dest_r) |
                       (wr_en & sel_fdata);                            // RL8
    assign mem_waddr = exec ? dec_idx_r : faddr_r;
    assign mem_wdata = exec ? dec_res : pwdata[7:0];
    assign mem_raddr = (state_r == ST_IDLE) ? faddr_r : dec_idx_r;

    wcd_file_mem #(
        .AW (IDX_W),
        .DW (8)
    ) u_mem (
        .pclk  (pclk),
        .ce    (ce),
        .we    (mem_we),
        .waddr (mem_waddr),
        .wdata (mem_wdata),
        .raddr (mem_raddr),
        .rdata (mem_rdata)
    );

    // ---------------------------------------------------------------
    // execution sequencer
    // ---------------------------------------------------------------
    // fetch operand, then execute; the array read latency is the
    // only reason the decrement spans more than the issuing edge
    always @*
    begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE:
            begin
                if (do_dec)
                    state_nxt = ST_READ;
            end
            ST_READ:
                state_nxt = ST_EXEC;
            ST_EXEC:
                state_nxt = ST_IDLE;
            default:
                state_nxt = ST_IDLE;
        endcase
    end

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_r    <= ST_IDLE;
            dec_idx_r  <= {IDX_W{1'b0}};
            dec_dest_r <= 1'b0;
            rd_wait_r  <= 1'b0;
            settle_r   <= 2'h0;
        end
        else if (ce)
        begin
            state_r   <= state_nxt;
            rd_wait_r <= fd_read & ~rd_wait_r;
            // without the settle time a read would return pre-decrement data
            if (exec)
                settle_r <= `WCD_SETTLE_CYC;
            else if (settle_r != 2'h0)
                settle_r <= settle_r - 2'h1;
            if (do_dec)
            begin
                dec_idx_r  <= opcode[`WCD_OP_IDX_MSB:0];               // RL5
                dec_dest_r <= opcode[`WCD_OP_DEST_BIT];                // RL5
            end
        end
    end

    // ---------------------------------------------------------------
    // accumulator and status flags
    // ---------------------------------------------------------------
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            acc_r    <= `WCD_RST_ACC;
            zero_r   <= 1'b0;
            pd_n_r   <= `WCD_RST_FLAG_N;
            to_n_r   <= `WCD_RST_FLAG_N;
            bad_op_r <= 1'b0;
            wdog_en_r <= 1'b0;
            faddr_r  <= {IDX_W{1'b0}};
        end
        else if (ce)
        begin
            if (wr_en & sel_ctrl)
                wdog_en_r <= pwdata[`WCD_CTRL_WDOG_EN];
            if (wr_en & sel_faddr)
                faddr_r <= pwdata[IDX_W-1:0];
            if (wr_en & sel_acc)
                acc_r <= pwdata[7:0];
            if (exec & ~dec_dest_r)
                acc_r <= dec_res;                                      // RL7
            if (wr_en & sel_status)
            begin
                zero_r <= pwdata[`WCD_ST_ZERO];
                pd_n_r <= pwdata[`WCD_ST_PD_N];
                to_n_r <= pwdata[`WCD_ST_TO_N];
            end
            if (exec)
                zero_r <= dec_zero;                                    // RL9
            // a timeout drops the flag unless the same edge clears the dog
            if (wdog_timeout_nxt)
                to_n_r <= 1'b0;
            if (do_clr)
            begin
                to_n_r <= 1'b1;                                        // RL3
                pd_n_r <= 1'b1;                                        // RL3
            end
            // sticky unknown-opcode flag; a new bad opcode beats the clear
            if (wr_en & sel_status & ~pwdata[`WCD_ST_BAD_OP])
                bad_op_r <= 1'b0;
            if (do_bad)
                bad_op_r <= 1'b1;
        end
    end

    // ---------------------------------------------------------------
    // watchdog counter and prescaler
    // ---------------------------------------------------------------
    assign pre_wrap         = (pre_r == {PRE_W{1'b1}});
    assign wdog_timeout_nxt = wdog_en_r & pre_wrap & (wdog_r == 8'hff) & ~do_clr;

    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wdog_r       <= `WCD_WDOG_CLEAR;
            pre_r        <= {PRE_W{1'b0}};
            wdog_timeout <= 1'b0;
        end
        else if (ce)
        begin
            wdog_timeout <= wdog_timeout_nxt;
            if (do_clr)
            begin
                wdog_r <= `WCD_WDOG_CLEAR;                             // RL1
                pre_r  <= {PRE_W{1'b0}};                               // RL2
            end
            else if (wdog_en_r)
            begin
                pre_r <= pre_r + {{(PRE_W-1){1'b0}}, 1'b1};
                if (pre_wrap)
                    wdog_r <= wdog_r + 8'h01;
            end
        end
    end

    // ---------------------------------------------------------------
    // read data
    // ---------------------------------------------------------------
    // read data is registered on every selected read edge, one edge before the access edge samples it
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h0000_0000;
        else if (ce & psel & ~pwrite)
        begin
            prdata <= 32'h0000_0000;
            if (sel_ctrl)
                prdata[`WCD_CTRL_WDOG_EN] <= wdog_en_r;
            if (sel_acc)
                prdata[7:0] <= acc_r;
            if (sel_status)
            begin
                prdata[`WCD_ST_ZERO]   <= zero_r;
                prdata[`WCD_ST_PD_N]   <= pd_n_r;
                prdata[`WCD_ST_TO_N]   <= to_n_r;
                prdata[`WCD_ST_BAD_OP] <= bad_op_r;
            end
            if (sel_wdog)
            begin
                prdata[7:0] <= wdog_r;
                prdata[`WCD_WD_PRE_LSB+PRE_W-1:`WCD_WD_PRE_LSB] <= pre_r;
            end
            if (sel_faddr)
                prdata[IDX_W-1:0] <= faddr_r;
            if (sel_fdata)
                prdata[7:0] <= mem_rdata;
        end
    end

    assign watchdog_counter = wdog_r;
    assign timeout_flag_n   = to_n_r;
    assign powerdown_flag_n = pd_n_r;
    assign zero_flag        = zero_r;

endmodule // wcd_core

// [rtl/wcd_regs.vh]
`ifndef WCD_REGS_VH
`define WCD_REGS_VH

// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define WCD_OFS_CTRL      12'h000
`define WCD_OFS_INSTR     12'h004
`define WCD_OFS_ACC       12'h008
`define WCD_OFS_STATUS    12'h00c
`define WCD_OFS_WDOG      12'h010
`define WCD_OFS_FADDR     12'h014
`define WCD_OFS_FDATA     12'h018

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define WCD_CTRL_WDOG_EN  0
`define WCD_ST_ZERO       0
`define WCD_ST_PD_N       1
`define WCD_ST_TO_N       2
`define WCD_ST_BAD_OP     3
`define WCD_WD_PRE_LSB    8

// ---------------------------------------------------------------
// opcode fields of the 14-bit program word
// ---------------------------------------------------------------
`define WCD_OP_WIDTH      14
`define WCD_OP_WDOG_CLR   14'h0064
`define WCD_OP_DEC_HI     6'h03
`define WCD_OP_HI_MSB     13
`define WCD_OP_HI_LSB     8
`define WCD_OP_DEST_BIT   7
`define WCD_OP_IDX_MSB    6

// ---------------------------------------------------------------
// reset values and constants
// ---------------------------------------------------------------
`define WCD_RST_ACC       8'h00
`define WCD_RST_FLAG_N    1'b1
`define WCD_WDOG_CLEAR    8'h00
`define WCD_DEC_STEP      8'h01
`define WCD_ZERO8         8'h00
`define WCD_SETTLE_CYC    2'h2

`endif

// [rtl/wcd_file_mem.v]
`timescale 1ns/1ps

// ---------------------------------------------------------------
// file register array, one write port, registered read data
// ---------------------------------------------------------------
module wcd_file_mem #(
    parameter AW = 7,
    parameter DW = 8
) (
    input  wire          pclk,
    input  wire          ce,
    input  wire          we,
    input  wire [AW-1:0] waddr,
    input  wire [DW-1:0] wdata,
    input  wire [AW-1:0] raddr,
    output reg  [DW-1:0] rdata
);

    reg [DW-1:0] mem [0:(1<<AW)-1];

    // read every enabled cycle; data appear one edge after the address
    always @(posedge pclk)
    begin
        if (ce)
        begin
            if (we)
                mem[waddr] <= wdata;
            rdata <= mem[raddr];
        end
    end

endmodule // wcd_file_mem

// [sim/wcd_core_properties.sv]
`timescale 1ns/1ps
`include "wcd_regs.vh"

// ------------------------------------------
// port checker for the core
// ------------------------------------------
module wcd_core_chk #(
    parameter PRE_W = 8,
    parameter IDX_W = 7
) (
    input wire        pclk,
    input wire        presetn,
    input wire        ce,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire        pready,
    input wire        pslverr,
    input wire [7:0]  watchdog_counter,
    input wire        timeout_flag_n,
    input wire        powerdown_flag_n,
    input wire        zero_flag,
    input wire        wdog_timeout
);
    // accepted transfers and the two issued operations
    wire acc_ok = psel && penable && pready;
    wire op_wr  = acc_ok && pwrite && paddr == `WCD_OFS_INSTR;
    wire clr_op = op_wr && pwdata[13:0] == `WCD_OP_WDOG_CLR;
    wire dec_op = op_wr && pwdata[13:8] == `WCD_OP_DEC_HI;

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    AST_CLR_CNT: assert property (clr_op |=> watchdog_counter == 8'h00)
        else $error("counter not cleared");
    AST_CLR_FLAGS: assert property (clr_op |=> timeout_flag_n && powerdown_flag_n)
        else $error("flags not set by clear");
    AST_CLR_ZERO: assert property (clr_op |=> zero_flag == $past(zero_flag))
        else $error("zero flag moved on clear");
    AST_DEC_STALL: assert property (dec_op |=> !pready)
        else $error("no stall after decrement");
    AST_DEC_BUSY: assert property (dec_op |=> !pready [*4])
        else $error("decrement stall too short");
    AST_DEC_PD: assert property (dec_op |-> ##3 powerdown_flag_n == $past(powerdown_flag_n, 3))
        else $error("power-down flag moved on decrement");
    AST_ERR_HI: assert property (acc_ok && paddr > `WCD_OFS_FDATA |-> pslverr)
        else $error("unmapped access not refused");
    AST_OK_MAP: assert property (acc_ok && paddr <= `WCD_OFS_FDATA && paddr[1:0] == 2'b00
        |-> !pslverr)
        else $error("mapped access refused");
    AST_CE_HOLD: assert property (!ce |-> !pready)
        else $error("ready while frozen");
    AST_TO_PULSE: assert property (wdog_timeout |-> watchdog_counter == 8'h00 ##1 !wdog_timeout)
        else $error("timeout pulse malformed");
endmodule // wcd_core_chk

bind wcd_core wcd_core_chk #(.PRE_W(PRE_W), .IDX_W(IDX_W)) u_chk (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .watchdog_counter(watchdog_counter),
    .timeout_flag_n(timeout_flag_n), .powerdown_flag_n(powerdown_flag_n),
    .zero_flag(zero_flag), .wdog_timeout(wdog_timeout));

// [sim/wcd_core_tb_top.sv]
`timescale 1ns/1ps
`include "wcd_regs.vh"

module wcd_core_tb_top;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        ce = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rdat, sw;
    logic        pready, pslverr, rerr, tmo, pdn, zf, dst, wto;
    logic [7:0]  cnt, val, res, acc_m;
    logic [6:0]  idx;
    int          n_mismatch = 0;
    int          checks_done = 0;
    int          n;

    // small prescaler keeps a full watchdog period near 1024 cycles
    wcd_core #(.PRE_W(2), .IDX_W(7)) u_dut (
        .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .watchdog_counter(cnt),
        .timeout_flag_n(tmo), .powerdown_flag_n(pdn), .zero_flag(zf),
        .wdog_timeout(wto));

    always #2 pclk = ~pclk;

    // ------------------------------------------
    // shared tasks
    // ------------------------------------------
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask

    // one apb transfer; a stall of 39 cycles or more ends the run
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 40);
        rdat = prdata;
        rerr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (n >= 40)
        begin
            n_mismatch++;
            finish_test();
        end
    endtask

    // ------------------------------------------
    // main sequence
    // ------------------------------------------
    initial
    begin
        void'($urandom(32'h1cdd));
        acc_m = 8'h00;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk("reset flags", 3'b110, {tmo, pdn, zf});
        chk("reset count", 8'h00, cnt);
        // corner values first: 0x00 wraps, 0x01 gives zero, both destinations
        for (int i = 0; i < 12; i++)
        begin
            idx = (i == 0) ? 7'h00 : (i == 1) ? 7'h7f : 7'($urandom);
            val = (i < 4) ? 8'(i % 2) : 8'($urandom);
            dst = (i < 4) ? i[1] : 1'($urandom);
            res = val - 8'h01;
            sw = $urandom & 32'h6;
            apb(1'b1, `WCD_OFS_STATUS, sw);
            apb(1'b1, `WCD_OFS_FADDR, {25'h0, idx});
            apb(1'b1, `WCD_OFS_FDATA, {24'h0, val});
            apb(1'b1, `WCD_OFS_INSTR, {18'h0, `WCD_OP_DEC_HI, dst, idx});
            if (!dst)
                acc_m = res;
            apb(1'b0, `WCD_OFS_ACC, 32'h0);
            chk("acc", acc_m, rdat);
            chk("zero", res == 8'h00, zf);
            apb(1'b0, `WCD_OFS_FDATA, 32'h0);
            chk("file", dst ? res : val, rdat);
            chk("flags kept", sw[2:1], {tmo, pdn});
        end
        // run the counter, freeze it, then clear with flags low and zero high
        apb(1'b1, `WCD_OFS_CTRL, 32'h1);
        repeat (40) @(posedge pclk);
        apb(1'b1, `WCD_OFS_CTRL, 32'h0);
        apb(1'b1, `WCD_OFS_STATUS, 32'h1);
        apb(1'b1, `WCD_OFS_INSTR, `WCD_OP_WDOG_CLR);
        @(posedge pclk);
        chk("count", 8'h00, cnt);
        chk("flags", 3'b111, {tmo, pdn, zf});
        apb(1'b0, `WCD_OFS_WDOG, 32'h0);
        chk("wdog", 32'h0, rdat);
        // let the watchdog expire, then recover with a clear
        apb(1'b1, `WCD_OFS_CTRL, 32'h1);
        n = 0;
        while (wto !== 1'b1 && n < 1200)
        begin
            @(posedge pclk);
            n++;
        end
        if (n >= 1200)
        begin
            n_mismatch++;
            finish_test();
        end
        chk("wrapped", 8'h00, cnt);
        repeat (2) @(posedge pclk);
        chk("expired", 1'b0, tmo);
        apb(1'b1, `WCD_OFS_INSTR, `WCD_OP_WDOG_CLR);
        @(posedge pclk);
        chk("recovered", 1'b1, tmo);
        apb(1'b1, `WCD_OFS_CTRL, 32'h0);
        // refusals: unmapped place, unknown opcode, write-only register
        apb(1'b1, 12'h01c, 32'hffffffff);
        chk("err", 1'b1, rerr);
        apb(1'b0, 12'h01c, 32'h0);
        chk("err rd", 1'b1, rerr);
        chk("err rd data", 32'h0, rdat);
        apb(1'b1, `WCD_OFS_INSTR, 32'h3fff);
        apb(1'b0, `WCD_OFS_STATUS, 32'h0);
        chk("bad op", 1'b1, rdat[`WCD_ST_BAD_OP]);
        apb(1'b0, `WCD_OFS_INSTR, 32'h0);
        chk("instr rd", 32'h0, rdat);
        ce <= 1'b0;
        repeat (3) @(posedge pclk);
        chk("frozen", 1'b0, pready);
        ce <= 1'b1;
        finish_test();
    end
endmodule // wcd_core_tb_top
